// *** rtl/t2cmp_timer.v ***
// 8-bit timer counter with one compare unit, output latch and pin mux,
// reached over an AHB-Lite slave port with zero wait states.
// Assumes one clock at 250 MHz, an asynchronous active-high reset, and that
// port data and direction inputs are synchronous to the same clock.
`timescale 1ns/100ps
`include "t2cmp_defs.vh"

module t2cmp_timer (
    input  wire        ref_clk_in,
    input  wire        reset_in,
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    input  wire        ovf_service_in,
    input  wire        cmp_service_in,
    output wire        ovf_request_out,
    output wire        cmp_request_out,
    input  wire        port_data_in,
    input  wire        port_dir_in,
    output reg         pin_out,
    output reg         pin_oe_n_out
);

    ////////////////////////////////////////////////////////////////////////
    // State
    reg [2:0]              clock_select_field_r;
    reg [1:0]              waveform_mode_select_r;
    reg [1:0]              compare_output_mode_r;
    reg [7:0]              counter_value_r;
    reg [7:0]              compare_value_reg_r;   // active compare register
    reg [7:0]              compare_buffer_r;      // CPU-side buffer in PWM modes
    reg                    overflow_flag_r;
    reg                    compare_match_flag_r;
    reg                    overflow_enable_r;
    reg                    compare_interrupt_enable_r;
    reg                    compare_output_latch_r;
    reg                    match_block_r;
    reg                    count_down_r;
    reg [`T2_PRE_W-1:0]    prescale_r;
    reg                    wr_pend_r;
    reg [`T2_ADDR_W-1:0]   wr_addr_r;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; a write lands in the data phase, one cycle after its address
    wire                   addr_take;
    wire [`T2_ADDR_W-1:0]  addr_ofs;
    wire                   wr_ctrl;
    wire                   wr_count;
    wire                   wr_compare;
    wire                   wr_flags;
    wire                   wr_enable;

    assign addr_take     = hsel_in && hready_in && (htrans_in == `T2_HTRANS_NONSEQ);
    assign addr_ofs      = haddr_in[`T2_ADDR_W-1:0];
    assign wr_ctrl       = wr_pend_r && (wr_addr_r == `T2_OFS_CTRL);
    assign wr_count      = wr_pend_r && (wr_addr_r == `T2_OFS_COUNT);
    assign wr_compare    = wr_pend_r && (wr_addr_r == `T2_OFS_COMPARE);
    assign wr_flags      = wr_pend_r && (wr_addr_r == `T2_OFS_FLAGS);
    assign wr_enable     = wr_pend_r && (wr_addr_r == `T2_OFS_ENABLE);
    assign hreadyout_out = 1'b1;               // Never stretches a transfer
    assign hresp_out     = `T2_HRESP_OKAY;

    // Only the low byte lane carries register data; other bits are ignored
    wire [7:0] wbyte;
    assign wbyte = hwdata_in[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    wire pwm_mode;
    wire buffered;
    assign pwm_mode = (waveform_mode_select_r == `T2_WGM_FASTPWM) ||
                      (waveform_mode_select_r == `T2_WGM_PCPWM);
    assign buffered = pwm_mode;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: free-running, so a tick period is exact once selected
    // The first tick after a rate change may come early; only later gaps are exact
    reg tick_sel;
    always @* begin
        case (clock_select_field_r)
            `T2_CS_DIV1:    tick_sel = 1'b1;
            `T2_CS_DIV8:    tick_sel = ((prescale_r & `T2_PRE_M8)    == `T2_PRE_M8);
            `T2_CS_DIV32:   tick_sel = ((prescale_r & `T2_PRE_M32)   == `T2_PRE_M32);
            `T2_CS_DIV64:   tick_sel = ((prescale_r & `T2_PRE_M64)   == `T2_PRE_M64);
            `T2_CS_DIV128:  tick_sel = ((prescale_r & `T2_PRE_M128)  == `T2_PRE_M128);
            `T2_CS_DIV256:  tick_sel = ((prescale_r & `T2_PRE_M256)  == `T2_PRE_M256);
            `T2_CS_DIV1024: tick_sel = ((prescale_r & `T2_PRE_M1024) == `T2_PRE_M1024);
            default:        tick_sel = 1'b0;
        endcase
    end

    // One-cycle timer clock enable
    wire timer_clock_enable;
    assign timer_clock_enable = tick_sel && (clock_select_field_r != `T2_CS_STOP);

    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            prescale_r <= {`T2_PRE_W{1'b0}};
        end else begin
            prescale_r <= prescale_r + {{(`T2_PRE_W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare, top and bottom detection
    wire at_match;
    wire at_max;
    wire at_bottom;
    wire real_match;
    assign at_match   = (counter_value_r == compare_value_reg_r);
    assign at_max     = (counter_value_r == `T2_MAX);
    assign at_bottom  = (counter_value_r == `T2_BOTTOM);
    // A match seen on a blocked tick is dropped for good, so loading the
    // counter equal to the compare value never fires when the clock starts
    assign real_match = timer_clock_enable && at_match && !match_block_r;

    ////////////////////////////////////////////////////////////////////////
    // Next counter value and overflow event
    reg [7:0] count_nxt;
    reg       dir_nxt;
    reg       ovf_event;
    reg       load_buffer;
    always @* begin
        count_nxt   = counter_value_r;
        dir_nxt     = count_down_r;
        ovf_event   = 1'b0;
        load_buffer = 1'b0;
        if (timer_clock_enable) begin
            case (waveform_mode_select_r)
                `T2_WGM_NORMAL: begin
                    count_nxt = counter_value_r + 8'h01;
                    ovf_event = at_max;
                end
                `T2_WGM_CTC: begin
                    if (real_match) begin
                        count_nxt = `T2_BOTTOM;
                    end else begin
                        count_nxt = counter_value_r + 8'h01;
                    end
                    ovf_event = at_max;
                end
                `T2_WGM_FASTPWM: begin
                    count_nxt   = counter_value_r + 8'h01;
                    ovf_event   = at_max;
                    load_buffer = at_max;
                end
                `T2_WGM_PCPWM: begin
                    if (at_max) begin
                        dir_nxt = 1'b1;
                    end else if (at_bottom) begin
                        dir_nxt = 1'b0;
                    end
                    if (dir_nxt) begin
                        count_nxt = counter_value_r - 8'h01;
                    end else begin
                        count_nxt = counter_value_r + 8'h01;
                    end
                    ovf_event   = at_bottom && count_down_r;
                    load_buffer = at_max;
                end
                default: begin
                    count_nxt = counter_value_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch action: real match per mode, or a forced match in non-PWM modes
    // A force is judged on the byte being written, so one write may choose the
    // output action and fire the strobe together; PWM modes ignore the strobe
    wire [1:0] wr_wgm;
    wire [1:0] act_com;
    wire       force_hit;
    wire       act_hit;
    assign wr_wgm    = wbyte[`T2_WGM_MSB:`T2_WGM_LSB];
    assign force_hit = wr_ctrl && wbyte[`T2_FOC_BIT] &&
                       (wr_wgm != `T2_WGM_FASTPWM) && (wr_wgm != `T2_WGM_PCPWM);
    assign act_com   = force_hit ? wbyte[`T2_COM_MSB:`T2_COM_LSB] : compare_output_mode_r;
    assign act_hit   = force_hit || (!pwm_mode && real_match);

    reg latch_nxt;
    always @* begin
        latch_nxt = compare_output_latch_r;
        if (act_hit) begin
            case (act_com)
                `T2_COM_TOGGLE: latch_nxt = !compare_output_latch_r;
                `T2_COM_CLEAR:  latch_nxt = 1'b0;
                `T2_COM_SET:    latch_nxt = 1'b1;
                default:        latch_nxt = compare_output_latch_r;
            endcase
        end else if (pwm_mode && timer_clock_enable &&
                     compare_output_mode_r[1]) begin
            // Simple PWM shaping: mode 2 non-inverted, mode 3 inverted
            if (real_match) begin
                latch_nxt = (count_down_r ^ compare_output_mode_r[0]);
            end else if (waveform_mode_select_r == `T2_WGM_FASTPWM && at_max) begin
                latch_nxt = !compare_output_mode_r[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, compare registers, latch and block state
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            counter_value_r        <= `T2_RST_BYTE;
            compare_value_reg_r    <= `T2_RST_BYTE;
            compare_buffer_r       <= `T2_RST_BYTE;
            compare_output_latch_r <= 1'b0;
            match_block_r          <= 1'b0;
            count_down_r           <= 1'b0;
        end else begin
            // CPU write overrides any count or clear in this cycle
            if (wr_count) begin
                counter_value_r <= wbyte;
                count_down_r    <= count_down_r;
            end else begin
                counter_value_r <= count_nxt;
                count_down_r    <= dir_nxt;
            end
            // Block holds until the next tick, however far away it is
            if (wr_count) begin
                match_block_r <= 1'b1;
            end else if (timer_clock_enable) begin
                match_block_r <= 1'b0;
            end
            // Outside PWM modes the buffer shadows the active register, so a
            // later switch into a PWM mode starts from the value last written
            if (wr_compare) begin
                compare_buffer_r <= wbyte;
                if (!buffered) begin
                    compare_value_reg_r <= wbyte;
                end
            end else if (buffered && load_buffer) begin
                compare_value_reg_r <= compare_buffer_r;
            end else if (!buffered) begin
                compare_buffer_r <= compare_value_reg_r;
            end
            compare_output_latch_r <= latch_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, flags and enables; a hardware set beats a clear in one cycle
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            clock_select_field_r       <= `T2_CS_STOP;
            waveform_mode_select_r     <= `T2_WGM_NORMAL;
            compare_output_mode_r      <= `T2_COM_OFF;
            overflow_flag_r            <= 1'b0;
            compare_match_flag_r       <= 1'b0;
            overflow_enable_r          <= 1'b0;
            compare_interrupt_enable_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                clock_select_field_r   <= wbyte[`T2_CS_MSB:`T2_CS_LSB];
                waveform_mode_select_r <= wbyte[`T2_WGM_MSB:`T2_WGM_LSB];
                compare_output_mode_r  <= wbyte[`T2_COM_MSB:`T2_COM_LSB];
            end
            // Service inputs come from the CPU side on this clock; no synchroniser
            if (ovf_event) begin
                overflow_flag_r <= 1'b1;
            end else if (ovf_service_in || (wr_flags && wbyte[`T2_OVF_BIT])) begin
                overflow_flag_r <= 1'b0;
            end
            // Forced matches never reach this flag
            if (real_match) begin
                compare_match_flag_r <= 1'b1;
            end else if (cmp_service_in || (wr_flags && wbyte[`T2_CMP_BIT])) begin
                compare_match_flag_r <= 1'b0;
            end
            if (wr_enable) begin
                overflow_enable_r          <= wbyte[`T2_OVF_BIT];
                compare_interrupt_enable_r <= wbyte[`T2_CMP_BIT];
            end
        end
    end

    assign ovf_request_out = overflow_flag_r && overflow_enable_r;
    assign cmp_request_out = compare_match_flag_r && compare_interrupt_enable_r;

    ////////////////////////////////////////////////////////////////////////
    // Bus phase tracking and registered read data
    reg [7:0] rd_byte;
    always @* begin
        case (addr_ofs)
            `T2_OFS_CTRL:    rd_byte = {1'b0, compare_output_mode_r,
                                        waveform_mode_select_r, clock_select_field_r};
            `T2_OFS_COUNT:   rd_byte = counter_value_r;
            `T2_OFS_COMPARE: rd_byte = buffered ? compare_buffer_r
                                                : compare_value_reg_r;
            `T2_OFS_FLAGS:   rd_byte = {6'h00, compare_match_flag_r, overflow_flag_r};
            `T2_OFS_ENABLE:  rd_byte = {6'h00, compare_interrupt_enable_r, overflow_enable_r};
            default:         rd_byte = `T2_RST_BYTE;
        endcase
    end

    // Read data is sampled in the address phase; a write in the cycle just
    // before is not yet visible, so back-to-back write then read reads old data
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= `T2_OFS_CTRL;
            hrdata_out <= `T2_WORD_ZERO;
        end else begin
            wr_pend_r <= addr_take && hwrite_in && (hsize_in == `T2_HSIZE_WORD);
            if (addr_take) begin
                wr_addr_r <= addr_ofs;
            end
            if (addr_take && !hwrite_in) begin
                hrdata_out <= {24'h000000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin mux: latch whenever a compare output mode is set; direction drives only the output enable
    // A registered pin costs a cycle of latency but never glitches
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_out      <= 1'b0;
            pin_oe_n_out <= 1'b1;
        end else begin
            pin_oe_n_out <= !port_dir_in;
            if (compare_output_mode_r != `T2_COM_OFF) begin
                pin_out <= compare_output_latch_r;
            end else begin
                pin_out <= port_data_in;
            end
        end
    end

endmodule // t2cmp_timer

// *** rtl/t2cmp_defs.vh ***
// Constants for the 8-bit timer compare unit: register map, field positions,
// mode codes and reset values. Definitions only; included by bare name.
`ifndef T2CMP_DEFS_VH
`define T2CMP_DEFS_VH

// Register byte offsets on the bus
`define T2_ADDR_W        8
`define T2_OFS_CTRL      8'h00
`define T2_OFS_COUNT     8'h04
`define T2_OFS_COMPARE   8'h08
`define T2_OFS_FLAGS     8'h0c
`define T2_OFS_ENABLE    8'h10

// Control register fields
`define T2_CS_LSB        0
`define T2_CS_MSB        2
`define T2_WGM_LSB       3
`define T2_WGM_MSB       4
`define T2_COM_LSB       5
`define T2_COM_MSB       6
`define T2_FOC_BIT       7

// Flag and enable register fields
`define T2_OVF_BIT       0
`define T2_CMP_BIT       1

// Waveform mode codes
`define T2_WGM_NORMAL    2'h0
`define T2_WGM_PCPWM     2'h1
`define T2_WGM_CTC       2'h2
`define T2_WGM_FASTPWM   2'h3

// Compare output mode codes
`define T2_COM_OFF       2'h0
`define T2_COM_TOGGLE    2'h1
`define T2_COM_CLEAR     2'h2
`define T2_COM_SET       2'h3

// Clock select codes and prescaler width
`define T2_CS_STOP       3'h0
`define T2_CS_DIV1       3'h1
`define T2_CS_DIV8       3'h2
`define T2_CS_DIV32      3'h3
`define T2_CS_DIV64      3'h4
`define T2_CS_DIV128     3'h5
`define T2_CS_DIV256     3'h6
`define T2_CS_DIV1024    3'h7
`define T2_PRE_W         10
`define T2_PRE_M8        10'h007
`define T2_PRE_M32       10'h01f
`define T2_PRE_M64       10'h03f
`define T2_PRE_M128      10'h07f
`define T2_PRE_M256      10'h0ff
`define T2_PRE_M1024     10'h3ff

// Count limits and reset values
`define T2_BOTTOM        8'h00
`define T2_MAX           8'hff
`define T2_RST_BYTE      8'h00
`define T2_RST_CTRL      8'h00

// Bus encodings
`define T2_HTRANS_NONSEQ 2'h2
`define T2_HRESP_OKAY    1'b0
`define T2_HSIZE_WORD    3'h2
`define T2_WORD_ZERO     32'h0000_0000

`endif

// *** dv/ebtcu_assertions.sv ***
// Concurrent checks on the timer compare unit's ports: bus, pin and flags.
// Bound to t2cmp_timer from the bench top; sees nothing but its ports.
`timescale 1ns/100ps
`include "t2cmp_defs.vh"
////////////////////////////////////////////////////////////////////////
module ebtcu_checker (
    input logic        ref_clk_in,
    input logic        reset_in,
    input logic        hsel_in,
    input logic [31:0] haddr_in,
    input logic [1:0]  htrans_in,
    input logic        hwrite_in,
    input logic [2:0]  hsize_in,
    input logic [31:0] hwdata_in,
    input logic        hready_in,
    input logic [31:0] hrdata_out,
    input logic        hreadyout_out,
    input logic        hresp_out,
    input logic        ovf_service_in,
    input logic        cmp_service_in,
    input logic        ovf_request_out,
    input logic        cmp_request_out,
    input logic        port_data_in,
    input logic        port_dir_in,
    input logic        pin_out,
    input logic        pin_oe_n_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////
    // Mirror of clock select and output mode, decoded from committed bus writes
    logic       wr_ctrl_r;
    logic [2:0] cs_r;
    logic [1:0] com_r;
    wire        rd_take = hsel_in & hready_in & (htrans_in == `T2_HTRANS_NONSEQ) & ~hwrite_in;
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_ctrl_r <= 1'b0;
            cs_r      <= `T2_CS_STOP;
            com_r     <= `T2_COM_OFF;
        end else begin
            wr_ctrl_r <= hsel_in & hready_in & (htrans_in == `T2_HTRANS_NONSEQ) & hwrite_in
                         & (hsize_in == 3'h2) & (haddr_in[7:0] == `T2_OFS_CTRL);
            if (wr_ctrl_r) begin
                cs_r  <= hwdata_in[`T2_CS_MSB:`T2_CS_LSB];
                com_r <= hwdata_in[`T2_COM_MSB:`T2_COM_LSB];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Service is judged only while stopped: a tick may set a flag again at the same edge
    sequence s_ovf_svc;
        (cs_r == `T2_CS_STOP) && ovf_service_in;
    endsequence
    sequence s_cmp_svc;
        (cs_r == `T2_CS_STOP) && cmp_service_in;
    endsequence
    a_ready_always: assert property (hreadyout_out) else $error("hreadyout low");
    a_resp_okay: assert property (hresp_out == `T2_HRESP_OKAY) else $error("response not okay");
    a_rdata_upper: assert property (hrdata_out[31:8] == 24'h000000) else $error("read data upper bits set");
    a_rdata_hold: assert property (!rd_take |=> $stable(hrdata_out)) else $error("read data moved");
    a_oe_tracks_dir: assert property (!$past(reset_in) |-> pin_oe_n_out == !$past(port_dir_in))
        else $error("pin enable does not follow direction");
    a_pin_port_src: assert property (!$past(reset_in) && com_r == `T2_COM_OFF && $past(com_r) == `T2_COM_OFF
        |-> pin_out == $past(port_data_in)) else $error("pin not from port logic");
    a_ovf_svc_clr: assert property (s_ovf_svc |=> !ovf_request_out) else $error("overflow not cleared");
    a_cmp_svc_clr: assert property (s_cmp_svc |=> !cmp_request_out) else $error("compare not cleared");
endmodule // ebtcu_checker

// *** dv/tb_eight_bit_timer_compare_unit.sv ***
// Self-checking bench for the timer compare unit over its AHB-Lite port.
// Assumes the design header and the checker file are compiled first.
`timescale 1ns/100ps
`include "t2cmp_defs.vh"
module tb_eight_bit_timer_compare_unit;
    logic        clk, rst, hsel, hwrite, ovf_svc, cmp_svc, pdata, pdir;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire  [31:0] hrdata;
    wire         hready, hresp, ovf_req, cmp_req, pin, pin_oe_n;
    int          errors, checked, n, i;
    logic [7:0]  q;
    t2cmp_timer uut (.ref_clk_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .ovf_service_in(ovf_svc), .cmp_service_in(cmp_svc),
        .ovf_request_out(ovf_req), .cmp_request_out(cmp_req), .port_data_in(pdata), .port_dir_in(pdir),
        .pin_out(pin), .pin_oe_n_out(pin_oe_n));
    ////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for hready; a stuck bus ends the run instead of hanging it
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 100);
        if (k >= 100) begin errors++; $display("BAD %0t bus hung", $time); finish_test; end
    endtask
    // One word transfer started just after a rising edge; it ends at the data-phase
    // edge, so back-to-back calls leave one idle cycle and no read meets a write's data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= `T2_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h000000, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_rdy;
        q = hrdata[7:0];
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    // Cycles between two pin changes, counted on the falling edge where the pin is settled
    task automatic gap;
        logic p;
        p = pin;
        n = 0;
        do begin @(negedge clk); n++; end while (pin === p && n < 300);
        if (n >= 300) begin errors++; $display("BAD %0t pin stuck", $time); finish_test; end
    endtask
    // One-cycle service pulse: overflow when cmp is low, compare when high
    task automatic pulse(input logic cmp);
        if (cmp) cmp_svc <= 1'b1;
        else ovf_svc <= 1'b1;
        @(posedge clk);
        {ovf_svc, cmp_svc} <= 2'b00;
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst, hsel, hwrite, ovf_svc, cmp_svc, pdata, pdir} = 7'h40;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        errors = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, including an unmapped offset that ignores writes
        for (i = 0; i < 6; i++) rdc(8'(4 * i), `T2_RST_BYTE);
        bus(1'b1, 8'h14, 8'hff);
        rdc(8'h14, 8'h00);
        chk({7'h0, pin_oe_n}, 8'h01);
        bus(1'b1, `T2_OFS_COUNT, 8'h5a);
        repeat (20) @(posedge clk);
        rdc(`T2_OFS_COUNT, 8'h5a);
        bus(1'b1, `T2_OFS_COMPARE, 8'h33);
        rdc(`T2_OFS_COMPARE, 8'h33);
        $display("test reset_and_stop done");
        // Normal mode wraps and raises the overflow flag, kept until serviced
        bus(1'b1, `T2_OFS_ENABLE, 8'h03);
        bus(1'b1, `T2_OFS_COUNT, 8'hfd);
        bus(1'b1, `T2_OFS_CTRL, 8'h01);
        n = 0;
        while (ovf_req !== 1'b1 && n < 20) begin @(negedge clk); n++; end
        if (n >= 20) begin errors++; $display("BAD %0t no overflow", $time); finish_test; end
        chk({7'h0, ovf_req}, 8'h01);
        bus(1'b1, `T2_OFS_CTRL, 8'h00);
        rdc(`T2_OFS_FLAGS, 8'h01);
        bus(1'b0, `T2_OFS_COUNT, 8'h00);
        chk({7'h0, q < 8'h08}, 8'h01);
        repeat (10) @(posedge clk);
        chk({7'h0, ovf_req}, 8'h01);
        pulse(1'b0);
        chk({7'h0, ovf_req}, 8'h00);
        $display("test normal_overflow done");
        // A counter write equal to the compare value loses that match
        bus(1'b1, `T2_OFS_COMPARE, 8'h40);
        bus(1'b1, `T2_OFS_COUNT, 8'h40);
        bus(1'b1, `T2_OFS_CTRL, 8'h01);
        repeat (60) @(posedge clk);
        bus(1'b1, `T2_OFS_CTRL, 8'h00);
        rdc(`T2_OFS_FLAGS, 8'h00);
        bus(1'b1, `T2_OFS_COUNT, 8'h3c);
        bus(1'b1, `T2_OFS_CTRL, 8'h01);
        repeat (30) @(posedge clk);
        bus(1'b1, `T2_OFS_CTRL, 8'h00);
        rdc(`T2_OFS_FLAGS, 8'h02);
        bus(1'b0, `T2_OFS_COUNT, 8'h00);
        chk({7'h0, q > 8'h40}, 8'h01);
        pulse(1'b1);
        chk({7'h0, cmp_req}, 8'h00);
        $display("test match_blocking done");
        // Clear-on-match toggle: half period is N*(1+compare) cycles for N of 1, 8 and 32
        @(posedge clk);
        pdir <= 1'b1;
        bus(1'b1, `T2_OFS_COUNT, 8'h00);
        bus(1'b1, `T2_OFS_COMPARE, 8'h03);
        for (i = 1; i < 4; i++) begin
            bus(1'b1, `T2_OFS_CTRL, 8'h30 | 8'(i));
            gap;
            gap;
            chk(8'(n), 8'(4 * (i == 1 ? 1 : i == 2 ? 8 : 32)));
            bus(1'b1, `T2_OFS_CTRL, 8'h30);
        end
        bus(1'b0, `T2_OFS_COUNT, 8'h00);
        chk({7'h0, q <= 8'h03}, 8'h01);
        rdc(`T2_OFS_FLAGS, 8'h02);
        bus(1'b1, `T2_OFS_FLAGS, 8'h03);
        rdc(`T2_OFS_FLAGS, 8'h00);
        chk({7'h0, pin_oe_n}, 8'h00);
        $display("test clear_on_match done");
        // Forced matches set or clear the latch only; mode and output changes keep it
        bus(1'b1, `T2_OFS_COUNT, 8'h02);
        bus(1'b1, `T2_OFS_CTRL, 8'hf0);
        repeat (2) @(negedge clk);
        chk({7'h0, pin}, 8'h01);
        bus(1'b1, `T2_OFS_CTRL, 8'hd0);
        repeat (2) @(negedge clk);
        chk({7'h0, pin}, 8'h00);
        rdc(`T2_OFS_FLAGS, 8'h00);
        rdc(`T2_OFS_COUNT, 8'h02);
        pdata <= 1'b1;
        bus(1'b1, `T2_OFS_CTRL, 8'h00);
        repeat (2) @(negedge clk);
        chk({7'h0, pin}, 8'h01);
        bus(1'b1, `T2_OFS_CTRL, 8'hf8);
        repeat (2) @(negedge clk);
        chk({7'h0, pin}, 8'h00);
        bus(1'b1, `T2_OFS_COMPARE, 8'h80);
        rdc(`T2_OFS_COMPARE, 8'h80);
        bus(1'b1, `T2_OFS_CTRL, 8'h00);
        rdc(`T2_OFS_COMPARE, 8'h03);
        // Running fast PWM moves the buffered value into the active register at max
        bus(1'b1, `T2_OFS_CTRL, 8'h18);
        bus(1'b1, `T2_OFS_COMPARE, 8'h80);
        bus(1'b1, `T2_OFS_CTRL, 8'h19);
        repeat (300) @(posedge clk);
        bus(1'b1, `T2_OFS_CTRL, 8'h00);
        rdc(`T2_OFS_COMPARE, 8'h80);
        $display("test force_and_buffer done");
        finish_test;
    end
endmodule // tb_eight_bit_timer_compare_unit
bind t2cmp_timer ebtcu_checker u_chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .ovf_service_in(ovf_service_in), .cmp_service_in(cmp_service_in),
    .ovf_request_out(ovf_request_out), .cmp_request_out(cmp_request_out), .port_data_in(port_data_in),
    .port_dir_in(port_dir_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out));
